/* rtl/sar_ctrl_pkg.sv */
// constants, modes, states and carriers of the conversion control
package sar_ctrl_pkg;

   // timing at the 100 MHz system clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACQ_TIME_NS = 300;
   localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_TIME_NS = 50;
   localparam int STEP_CYCLES_RAW = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam int STEP_CYCLES = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;

   // counter widths and derived terminal counts
   localparam int ACQ_CNT_W = 8;
   localparam int STEP_CNT_W = 4;
   localparam logic [ACQ_CNT_W-1:0] ACQ_COUNT = ACQ_CNT_W'(ACQ_CYCLES);
   localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

   // conversion word
   localparam int CODE_W = 18;
   localparam int IDX_W = 5;
   localparam logic [CODE_W-1:0] CODE_MSB_TRIAL = 18'h20000;
   localparam logic [IDX_W-1:0] IDX_MSB = 5'h11;
   localparam int COUNT_W = 16;

   // register byte addresses
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] CTRL_ADDR = 4'h0;
   localparam logic [ADR_W-1:0] STATUS_ADDR = 4'h4;
   localparam logic [ADR_W-1:0] RESULT_ADDR = 4'h8;
   localparam logic [ADR_W-1:0] COUNT_ADDR = 4'hc;

   typedef enum logic [1:0] {
      MODE_WARP = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_IMPULSE = 2'b10
   } mode_t;

   localparam logic [1:0] MODE_RESET = 2'b01;

   typedef enum logic [1:0] {
      ST_ACQ = 2'b00,
      ST_CONV = 2'b01,
      ST_FINISH = 2'b10,
      ST_PDOWN = 2'b11
   } conv_state_t;

   // status word, bit 4 first
   typedef struct packed {
      logic ref_buf_on;
      logic powered_down;
      logic acq_done;
      logic low_power;
      logic busy;
   } status_t;

   // wishbone request carrier
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

endpackage : sar_ctrl_pkg

/* rtl/step_tick_gen.sv */
// divider giving one-cycle conversion step enables
`timescale 1ns/1ps
module step_tick_gen #(
   parameter int W = 4,
   parameter logic [W-1:0] LAST = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   output logic tick_o
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      tick_o = 1'b0;
      if (!run_i) begin
         cnt_next = '0;
      end else if (cnt_reg == LAST) begin
         cnt_next = '0;
         tick_o = 1'b1;
      end else begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : step_tick_gen

/* rtl/sar_engine.sv */
// successive approximation bit decisions, msb first
`timescale 1ns/1ps
module sar_engine
   import sar_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic start_i,
   input wire logic tick_i,
   input wire logic comp_i,
   // results
   output logic active_o,
   output logic done_o,
   output logic [CODE_W-1:0] code_o
);
   logic [CODE_W-1:0] code_reg;
   logic [CODE_W-1:0] code_next;
   logic [IDX_W-1:0] idx_reg;
   logic [IDX_W-1:0] idx_next;
   logic active_reg;
   logic active_next;
   logic done_reg;
   logic done_next;

   always_comb begin
      code_next = code_reg;
      idx_next = idx_reg;
      active_next = active_reg;
      done_next = 1'b0;
      if (start_i) begin
         code_next = CODE_MSB_TRIAL;
         idx_next = IDX_MSB;
         active_next = 1'b1;
      end else if (active_reg && tick_i) begin
         // keep the trial bit when the comparator says input is above
         code_next[idx_reg] = comp_i;
         if (idx_reg != '0) begin
            code_next[idx_reg - IDX_W'(1)] = 1'b1;
         end else begin
            active_next = 1'b0;
            done_next = 1'b1;
         end
         idx_next = idx_reg - IDX_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_reg <= '0;
         idx_reg <= '0;
         active_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         code_reg <= code_next;
         idx_reg <= idx_next;
         active_reg <= active_next;
         done_reg <= done_next;
      end
   end

   assign active_o = active_reg;
   assign done_o = done_reg;
   assign code_o = code_reg;
endmodule : sar_engine

/* rtl/sar_conversion_control.sv */
// conversion control of the sar converter with a wishbone register slave
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module sar_conversion_control
   import sar_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // conversion pins
   input wire logic convert_start_n_i,
   input wire logic power_down_request_i,
   input wire logic ref_buffer_powerdown_i,
   input wire logic comparator_i,
   output logic busy_o,
   output logic low_power_o,
   output logic powered_down_o,
   output logic ref_buffer_on_o,
   // parallel result port
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   output logic [CODE_W-1:0] data_o,
   output logic data_oe_n_o
);
   wb_req_t req;
   status_t status;

   conv_state_t state_reg;
   conv_state_t state_next;
   logic [ACQ_CNT_W-1:0] acq_cnt_reg;
   logic [ACQ_CNT_W-1:0] acq_cnt_next;
   logic auto_reg;
   logic auto_next;
   logic busy_reg;
   logic busy_next;
   logic low_power_reg;
   logic low_power_next;
   logic [CODE_W-1:0] result_reg;
   logic [CODE_W-1:0] result_next;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic start_prev_reg;
   logic ref_on_reg;
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [CODE_W-1:0] data_reg;
   logic oe_n_reg;
   logic pd_reg;
   logic pd_next;

   logic start_fall;
   logic acq_done;
   logic impulse;
   logic self_start;
   logic sar_start;
   logic sar_active;
   logic sar_done;
   logic [CODE_W-1:0] sar_code;
   logic step_tick;

   step_tick_gen #(
      .W(STEP_CNT_W),
      .LAST(STEP_LAST)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(sar_active),
      .tick_o(step_tick)
   );

   sar_engine u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(sar_start),
      .tick_i(step_tick),
      .comp_i(comparator_i),
      .active_o(sar_active),
      .done_o(sar_done),
      .code_o(sar_code)
   );

   // start edge and acquisition state
   assign start_fall = start_prev_reg & ~convert_start_n_i;
   assign acq_done = (acq_cnt_reg == ACQ_COUNT);
   assign impulse = (mode_reg == MODE_IMPULSE);
   assign self_start = auto_reg & impulse & ~convert_start_n_i;

   // conversion sequencer
   always_comb begin
      state_next = state_reg;
      acq_cnt_next = acq_cnt_reg;
      auto_next = auto_reg;
      busy_next = busy_reg;
      low_power_next = low_power_reg;
      result_next = result_reg;
      count_next = count_reg;
      sar_start = 1'b0;
      case (state_reg)
         ST_ACQ: begin
            if (!acq_done) begin
               acq_cnt_next = acq_cnt_reg + ACQ_CNT_W'(1);
            end
            if (convert_start_n_i) begin
               auto_next = 1'b0;
            end
            if (acq_done && (start_fall || self_start)) begin
               sar_start = 1'b1;
               state_next = ST_CONV;
               busy_next = 1'b1;
               low_power_next = 1'b0;
               auto_next = 1'b0;
            end else if (power_down_request_i) begin
               state_next = ST_PDOWN;
               low_power_next = 1'b1;
            end
         end
         ST_CONV: begin
            // start edges and power-down are not looked at here
            if (sar_done) begin
               result_next = sar_code;
               state_next = ST_FINISH;
            end
         end
         ST_FINISH: begin
            busy_next = 1'b0;
            count_next = count_reg + COUNT_W'(1);
            acq_cnt_next = '0;
            auto_next = impulse & ~convert_start_n_i;
            low_power_next = impulse;
            state_next = ST_ACQ;
         end
         ST_PDOWN: begin
            if (!power_down_request_i) begin
               state_next = ST_ACQ;
               acq_cnt_next = '0;
               low_power_next = impulse;
            end
         end
         default: begin
            state_next = ST_ACQ;
         end
      endcase
      pd_next = (state_next == ST_PDOWN);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_ACQ;
         acq_cnt_reg <= '0;
         auto_reg <= 1'b0;
         busy_reg <= 1'b0;
         low_power_reg <= 1'b0;
         result_reg <= '0;
         count_reg <= '0;
         start_prev_reg <= 1'b1;
         ref_on_reg <= 1'b0;
         pd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         acq_cnt_reg <= acq_cnt_next;
         auto_reg <= auto_next;
         busy_reg <= busy_next;
         low_power_reg <= low_power_next;
         result_reg <= result_next;
         count_reg <= count_next;
         start_prev_reg <= convert_start_n_i;
         ref_on_reg <= ~ref_buffer_powerdown_i;
         pd_reg <= pd_next;
      end
   end

   // register slave, answered in every power state
   always_comb begin
      req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
              sel: wb_sel_i, dat: wb_dat_i};
      status = '{ref_buf_on: ref_on_reg, powered_down: pd_reg,
                 acq_done: acq_done, low_power: low_power_reg,
                 busy: busy_reg};
      ack_next = req.cyc & req.stb & ~ack_reg;
      mode_next = mode_reg;
      rdata_next = rdata_reg;
      if (ack_next) begin
         case (req.adr)
            CTRL_ADDR: rdata_next = {30'h0, mode_reg};
            STATUS_ADDR: rdata_next = {27'h0, status};
            RESULT_ADDR: rdata_next = {14'h0, result_reg};
            COUNT_ADDR: rdata_next = {16'h0, count_reg};
            default: rdata_next = 32'h0;
         endcase
      end
      if (req.cyc && req.stb && req.we && ack_reg && req.sel[0] &&
          req.adr == CTRL_ADDR) begin
         mode_next = req.dat[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
         mode_reg <= MODE_RESET;
         data_reg <= '0;
         oe_n_reg <= 1'b1;
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         mode_reg <= mode_next;
         data_reg <= result_reg;
         oe_n_reg <= cs_n_i | rd_n_i;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign busy_o = busy_reg;
   assign low_power_o = low_power_reg;
   assign powered_down_o = pd_reg;
   assign ref_buffer_on_o = ref_on_reg;
   assign data_o = data_reg;
   assign data_oe_n_o = oe_n_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   start_accept_a: assert property (
      (state_reg == ST_ACQ && acq_done && start_fall) |=> busy_o ##1 busy_o)
      else $error("start after acquisition not taken");

   code_then_busy_a: assert property (
      (state_reg == ST_CONV && sar_done) |=>
         (busy_o && result_reg == $past(sar_code)) ##1 !busy_o)
      else $error("busy fell before code was stored");

   no_abort_a: assert property (
      (state_reg == ST_CONV && !sar_done) |=> (state_reg == ST_CONV && busy_o))
      else $error("conversion aborted or restarted");

   cs_rd_free_a: assert property (
      (state_reg == ST_ACQ && acq_done && start_fall && (cs_n_i || rd_n_i))
         |=> busy_o)
      else $error("start gated by chip-select or read");

   self_start_a: assert property (
      (state_reg == ST_ACQ && acq_done && auto_reg && impulse &&
       !convert_start_n_i) |=> busy_o)
      else $error("impulse self start missing");

   no_self_start_a: assert property (
      (state_reg == ST_ACQ && !impulse && !start_fall) |=> !$rose(busy_o))
      else $error("conversion started without a start edge");

   low_power_end_a: assert property (
      ($fell(busy_o) && $past(impulse)) |-> low_power_o)
      else $error("low power not entered at conversion end");

   iface_alive_a: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o && low_power_o) |=> wb_ack_o)
      else $error("bus not answered in low power");

   ref_buffer_a: assert property (
      ref_buffer_powerdown_i |=> !ref_buffer_on_o)
      else $error("reference buffer on during power-down");

   ref_buffer_on_a: assert property (
      !ref_buffer_powerdown_i |=> ref_buffer_on_o)
      else $error("reference buffer off while enabled");

   pdown_ignored_a: assert property (
      (state_reg == ST_CONV && power_down_request_i) |=> !powered_down_o)
      else $error("power-down taken during conversion");

   pdown_taken_a: assert property (
      (state_reg == ST_ACQ && power_down_request_i &&
       !(acq_done && (start_fall || self_start)))
         |=> (powered_down_o && low_power_o))
      else $error("power-down not entered from acquisition");

   busy_frame_a: assert property (
      $rose(busy_o) |-> (state_reg == ST_CONV) ##0 busy_o [*8])
      else $error("busy pulse too short");

endmodule : sar_conversion_control

/* tb/sar_host_model.sv */
// host model driving conversion start and the comparator
`timescale 1ns/1ps
module sar_host_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // commands from the bench
   input wire logic start_req_i,
   input wire logic hold_i,
   input wire logic level_i,
   // towards the converter
   output logic convert_start_n_o,
   output logic comparator_o
);
   // start idles high; a one-cycle low pulse or a held low level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         convert_start_n_o <= 1'b1;
      end else begin
         convert_start_n_o <= ~(start_req_i | hold_i);
      end
   end
   // a constant analog level decides every trial bit
   assign comparator_o = level_i;
endmodule : sar_host_model

/* tb/sar_conversion_control_tb.sv */
// self-checking bench of the conversion control
`timescale 1ns/1ps
module sar_conversion_control_tb;
   import sar_ctrl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, dat_o, rd;
   logic req = 1'b0, hold = 1'b0, level = 1'b0, start_n, comp;
   logic pdr = 1'b0, rbpd = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
   logic busy, lp, pd, rbon, oe_n, hit;
   logic [CODE_W-1:0] data;
   int mismatches = 0;
   int tests_run = 0;
   int n;

   always #5 clk_i = ~clk_i;

   sar_host_model host (.clk_i(clk_i), .rst_i(rst_i), .start_req_i(req),
      .hold_i(hold), .level_i(level), .convert_start_n_o(start_n),
      .comparator_o(comp));

   sar_conversion_control dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .convert_start_n_i(start_n), .power_down_request_i(pdr),
      .ref_buffer_powerdown_i(rbpd), .comparator_i(comp), .busy_o(busy),
      .low_power_o(lp), .powered_down_o(pd), .ref_buffer_on_o(rbon),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .data_o(data), .data_oe_n_o(oe_n));

   task check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task summarize;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask : tick

   // single classic cycle, held until ack is sampled
   task wb(input logic w, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= wd;
      do @(posedge clk_i); while (ack !== 1'b1);
      d = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task wait_busy(input logic v, input int k, output logic h);
      h = 1'b0;
      for (int i = 0; i < k && !h; i++) begin
         @(posedge clk_i);
         h = (busy === v);
      end
   endtask : wait_busy

   // one conversion with a second start and power-down while busy
   task t_conv(input logic lvl, input logic [17:0] code, input int cnt);
      level <= lvl;
      @(posedge clk_i);
      req <= 1'b1;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      @(posedge clk_i);
      req <= 1'b0;
      @(posedge clk_i);
      @(posedge clk_i);
      check("busy rise", 32'(busy), 32'h1);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         n++;
         if (n == 20) begin
            req <= 1'b1;
            pdr <= 1'b1;
         end
         if (n == 21) req <= 1'b0;
         if (n == 25) check("pd in conv", 32'(pd), 32'h0);
         if (n == 30) pdr <= 1'b0;
         @(posedge clk_i);
      end
      check("busy length", n, 92);
      wb(1'b0, RESULT_ADDR, 32'h0, rd);
      check("result", rd, 32'(code));
      check("data pins", 32'(data), 32'(code));
      check("data drive", 32'(oe_n), 32'h0);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      tick(40);
      check("no queued start", 32'(busy), 32'h0);
      wb(1'b0, COUNT_ADDR, 32'h0, rd);
      check("count", rd, 32'(cnt));
      $display("test conversion done");
   endtask : t_conv

   // start held low in one mode
   task t_auto(input logic [1:0] m);
      wb(1'b1, CTRL_ADDR, 32'(m), rd);
      tick(40);
      hold <= 1'b1;
      wait_busy(1'b1, 10, hit);
      check("first start", 32'(hit), 32'h1);
      wait_busy(1'b0, 120, hit);
      check("first end", 32'(hit), 32'h1);
      check("low power", 32'(lp), 32'(m == MODE_IMPULSE));
      wb(1'b0, STATUS_ADDR, 32'h0, rd);
      check("status", 32'(rd[1:0]), 32'(m == MODE_IMPULSE) << 1);
      wait_busy(1'b1, 60, hit);
      check("self start", 32'(hit), 32'(m == MODE_IMPULSE));
      hold <= 1'b0;
      wait_busy(1'b0, 120, hit);
      tick(40);
      check("stopped", 32'(busy), 32'h0);
      $display("test held start mode %0d done", m);
   endtask : t_auto

   task t_power;
      rbpd <= 1'b0;
      tick(3);
      check("buffer on", 32'(rbon), 32'h1);
      rbpd <= 1'b1;
      tick(3);
      check("buffer off", 32'(rbon), 32'h0);
      pdr <= 1'b1;
      tick(3);
      check("powered down", 32'(pd), 32'h1);
      check("pd low power", 32'(lp), 32'h1);
      pdr <= 1'b0;
      tick(40);
      $display("test power done");
   endtask : t_power

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      check("reset busy", 32'(busy), 32'h0);
      check("reset drive", 32'(oe_n), 32'h1);
      wb(1'b0, CTRL_ADDR, 32'h0, rd);
      check("mode reset", rd, 32'(MODE_RESET));
      wb(1'b0, 4'h2, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      tick(40);
      t_conv(1'b1, 18'h3ffff, 1);
      t_conv(1'b0, 18'h00000, 2);
      for (int m = 0; m < 3; m++) begin
         t_auto(2'(m));
      end
      t_power;
      summarize;
   end

   initial begin
      repeat (4000) @(posedge clk_i);
      mismatches++;
      summarize;
   end
endmodule : sar_conversion_control_tb
